// ===== rtl/rrs_defs.svh
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH
// ----------------------------------------
// opcode fields of the 16-bit program word
// ----------------------------------------
`define RRS_OPC_MSB      15
`define RRS_OPC_LSB      9
`define RRS_SEL_BIT      8
`define RRS_ADDR_MSB     7
`define RRS_OPC_RRNC     7'h10
`define RRS_OPC_SET_FILE_ALL_ONES_OP     7'h15
`define RRS_ALL_ONES     8'hFF
`define RRS_WORKING_REGISTER_RESET   8'h00
`define RRS_ADDR_LSB     0
`define RRS_BIT0         0
`define RRS_DATA_W       8
`define RRS_ZERO_BYTE    8'h00
`endif

// ===== rtl/rrs_pkg.sv
`default_nettype none
package rrs_pkg;
  typedef enum logic [1:0] {
    RRS_Q1,
    RRS_Q2,
    RRS_Q3,
    RRS_Q4
  } rrs_phase_e;

  typedef enum logic [1:0] {
    RRS_OP_NONE,
    RRS_OP_ROTATE,
    RRS_OP_SET
  } rrs_op_e;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rrs_wr_s;
endpackage
`default_nettype wire

// ===== rtl/rrs_exec.sv
`include "rrs_defs.svh"
`default_nettype none
module rrs_exec
  import rrs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic [15:0] instr_i,
  input  wire logic [7:0]  file_rdata_i,
  output var  logic [1:0]  phase_o,
  output var  logic [7:0]  file_raddr_o,
  output var  logic        file_re_o,
  output var  rrs_wr_s     file_wr_o,
  output var  logic [7:0]  working_register_o,
  output var  logic        instr_done_o
);
  // ----------------------------------------
  // storage and decode nets
  // ----------------------------------------
  localparam int DW = `RRS_DATA_W;
  localparam int OW = `RRS_OPC_MSB - `RRS_OPC_LSB + 1;

  rrs_phase_e    phase_q;
  rrs_op_e       op_q;
  logic          sel_q;
  logic [7:0]    addr_q;
  logic [DW-1:0] data_q;
  logic [OW-1:0] opc_w;
  logic          is_rot_w;
  logic          is_set_w;
  logic          known_w;
  logic          dest_file_w;
  logic          dest_working_register_w;
  logic [DW-1:0] rot_w;

  // ----------------------------------------
  // phase sequencer
  // ----------------------------------------
  // free running: one instruction every four clocks, no stall input exists
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_q <= RRS_Q1;
    end else begin
      case (phase_q)
        RRS_Q1:  phase_q <= RRS_Q2;
        RRS_Q2:  phase_q <= RRS_Q3;
        RRS_Q3:  phase_q <= RRS_Q4;
        RRS_Q4:  phase_q <= RRS_Q1;
        default: phase_q <= RRS_Q1;
      endcase
    end
  end

  // ----------------------------------------
  // opcode match
  // ----------------------------------------
  // the select bit stays out of the match
  always_comb begin
    opc_w    = instr_i[`RRS_OPC_MSB:`RRS_OPC_LSB];
    is_rot_w = 1'b0;
    is_set_w = 1'b0;
    case (opc_w)
      `RRS_OPC_RRNC: begin
        is_rot_w = 1'b1;
      end
      `RRS_OPC_SET_FILE_ALL_ONES_OP: begin
        is_set_w = 1'b1;
      end
      default: begin
        is_rot_w = 1'b0;
        is_set_w = 1'b0;
      end
    endcase
    known_w  = is_rot_w || is_set_w;
  end

  // ----------------------------------------
  // decode, phase one
  // ----------------------------------------
  // one word holds the whole instruction, so one fetch is enough
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op_q <= RRS_OP_NONE;
    end else if (phase_q == RRS_Q1) begin
      if (is_rot_w) begin
        op_q <= RRS_OP_ROTATE;
      end else if (is_set_w) begin
        op_q <= RRS_OP_SET;
      end else begin
        op_q <= RRS_OP_NONE;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sel_q  <= 1'b0;
      addr_q <= `RRS_ZERO_BYTE;
    end else if (phase_q == RRS_Q1) begin
      sel_q  <= instr_i[`RRS_SEL_BIT];
      addr_q <= instr_i[`RRS_ADDR_MSB:`RRS_ADDR_LSB];
    end
  end

  // ----------------------------------------
  // file read, phase two
  // ----------------------------------------
  // set also reads; the value is dropped, but memory sees one timing for both
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      file_re_o <= 1'b0;
    end else begin
      file_re_o <= (phase_q == RRS_Q1) && known_w;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      file_raddr_o <= `RRS_ZERO_BYTE;
    end else if (phase_q == RRS_Q1) begin
      file_raddr_o <= instr_i[`RRS_ADDR_MSB:`RRS_ADDR_LSB];
    end
  end

  // ----------------------------------------
  // rotate right, one slice per bit
  // ----------------------------------------
  // slice n takes old bit n+1; the top slice takes old bit 0, carry never enters
  for (genvar b = 0; b < DW; b++) begin : g_rot
    if (b == DW - 1) begin : g_wrap
      assign rot_w[b] = file_rdata_i[`RRS_BIT0];
    end else begin : g_shift
      assign rot_w[b] = file_rdata_i[b + 1];
    end
  end

  // ----------------------------------------
  // process data, phase three
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      data_q <= `RRS_ZERO_BYTE;
    end else if (phase_q == RRS_Q2) begin
      if (op_q == RRS_OP_SET) begin
        data_q <= `RRS_ALL_ONES;
      end else begin
        data_q <= rot_w;
      end
    end
  end

  // ----------------------------------------
  // destination select
  // ----------------------------------------
  // set always writes the file; select only decides about the working register
  always_comb begin
    dest_file_w = 1'b0;
    dest_working_register_w = 1'b0;
    case (op_q)
      RRS_OP_ROTATE: begin
        dest_file_w = sel_q;
        dest_working_register_w = !sel_q;
      end
      RRS_OP_SET: begin
        dest_file_w = 1'b1;
        dest_working_register_w = !sel_q;
      end
      default: begin
        dest_file_w = 1'b0;
        dest_working_register_w = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // write to destination, phase four
  // ----------------------------------------
  // strobe rises on the edge into phase four and lasts that one phase
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      file_wr_o <= '0;
    end else begin
      file_wr_o.en   <= (phase_q == RRS_Q3) && dest_file_w;
      file_wr_o.addr <= addr_q;
      file_wr_o.data <= data_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      working_register_o <= `RRS_WORKING_REGISTER_RESET;
    end else if ((phase_q == RRS_Q3) && dest_working_register_w) begin
      working_register_o <= data_q;
    end
  end

  // ----------------------------------------
  // phase copy and completion
  // ----------------------------------------
  // no status register lives here, so neither opcode can touch a flag
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_o <= RRS_Q1;
    end else begin
      phase_o <= phase_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      instr_done_o <= 1'b0;
    end else begin
      instr_done_o <= (phase_q == RRS_Q3) && (op_q != RRS_OP_NONE);
    end
  end
endmodule
`default_nettype wire

// ===== sim/rrs_exec_assertions.sv
`default_nettype none
// --------
// checks
// --------
module rrs_exec_assertions import rrs_pkg::*; (
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0]  file_rdata_i,
  input wire logic        file_re_o,
  input wire rrs_wr_s     file_wr_o,
  input wire logic [7:0]  working_register_o,
  input wire logic        instr_done_o
);
  logic [15:0] i1, i2, i3;
  logic [7:0]  r1, r2;
  wire  [7:0]  rot = {r2[0], r2[7:1]};
  // delay line instead of deep past calls; r2 holds the word read in phase two
  always_ff @(posedge clk_i) {i3, i2, i1, r2, r1} <= {i2, i1, instr_i, r1, file_rdata_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rot_wrap: assert property (
    file_wr_o.en && i3[15:9] == 7'h10 |-> file_wr_o.data == rot) else $error("rot data");
  a_rot_working_register: assert property (
    instr_done_o && i3[15:8] == 8'h20 |-> !file_wr_o.en ##1 working_register_o == $past(rot))
    else $error("rot working_register");
  a_rot_back: assert property (
    instr_done_o && i3[15:8] == 8'h21 |-> file_wr_o.en && file_wr_o.addr == i3[7:0])
    else $error("rot back");
  a_rot_keep: assert property (
    instr_done_o && i3[15:8] == 8'h21 |-> $stable(working_register_o)) else $error("rot keep");
  a_set_both: assert property (
    instr_done_o && i3[15:8] == 8'h2A |-> file_wr_o.en && file_wr_o.data == 8'hFF
    ##1 working_register_o == 8'hFF) else $error("set both");
  a_set_only: assert property (
    instr_done_o && i3[15:8] == 8'h2B |-> file_wr_o.en && $stable(working_register_o))
    else $error("set only");
  a_read_phase: assert property (
    file_wr_o.en |-> $past(file_re_o, 2)) else $error("read phase");
  a_one_cycle: assert property (
    instr_done_o |=> !instr_done_o [*3]) else $error("done spacing");
  c_rot: cover property (instr_done_o && !file_wr_o.en);
  c_set: cover property (file_wr_o.en && file_wr_o.data == 8'hFF);
  c_read: cover property (file_re_o);
endmodule
bind rrs_exec rrs_exec_assertions u_chk (.clk_i, .reset_i, .instr_i, .file_rdata_i,
  .file_re_o, .file_wr_o, .working_register_o, .instr_done_o);
`default_nettype wire

// ===== sim/rrs_exec_test.sv
`default_nettype none
// --------
// bench
// --------
module rrs_exec_test import rrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, reset_i = 1, re, done;
  logic [15:0] instr_i = 0, lf = 16'h0028;
  logic [1:0]  ph;
  logic [7:0]  rd = 0, wm = 0, ra, working_register;
  logic [7:0]  ops [4] = '{8'h20, 8'h21, 8'h2A, 8'h2B};
  logic [24:0] e;
  rrs_wr_s     wr;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  rrs_exec dut (.clk_i, .reset_i, .instr_i, .file_rdata_i(rd), .phase_o(ph), .file_raddr_o(ra),
    .file_re_o(re), .file_wr_o(wr), .working_register_o(working_register), .instr_done_o(done));
  function automatic logic [15:0] nx(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // {working register, write}; write fields only matter when enabled
  function automatic logic [24:0] model(logic [15:0] w, logic [7:0] r, logic [7:0] o);
    logic [7:0] v;
    v = w[9] ? 8'hFF : {r[0], r[7:1]};
    case (w[15:8])
      8'h20: return {v, 17'h0};
      8'h21, 8'h2B: return {o, 1'b1, w[7:0], v};
      8'h2A: return {v, 1'b1, w[7:0], v};
      default: return {o, 17'h0};
    endcase
  endfunction
  task automatic chk(logic [24:0] g, logic [24:0] x);
    tests_run++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc > 400) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    #1 reset_i = 0;
    for (int i = 0; i < 40; i++) begin
      lf = nx(lf);
      instr_i = {(i % 5 == 4) ? lf[15:8] : ops[i % 4], lf[7:0]};
      @(posedge clk_i);
      // first pass uses 01 so the wrap bit is seen on both rotate ops
      #1 rd = (i < 4) ? 8'h01 : lf[15:8] ^ lf[7:0];
      chk({re, ra}, {instr_i[15:9] == 7'h10 || instr_i[15:9] == 7'h15, instr_i[7:0]});
      chk(ph, RRS_Q1);
      e = model(instr_i, rd, wm);
      repeat (2) @(posedge clk_i);
      #1 rd = ~rd;
      chk(wr.en ? wr : 17'h0, e[16:0]);
      chk(done, instr_i[15:9] == 7'h10 || instr_i[15:9] == 7'h15);
      chk(ph, RRS_Q3);
      @(posedge clk_i);
      #1 chk(working_register, e[24:17]);
      wm = e[24:17];
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule
`default_nettype wire
